// ### hw/ldc_defines.svh
// constants for the lamp driver control block
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

// ****************************************
// clock
// ****************************************
`define LDC_CLK_PERIOD_NS   10

// ****************************************
// configuration register fields
// ****************************************
`define LDC_CFG_RESET       8'h18
`define LDC_CFG_USED_MASK   8'h9b
`define LDC_CFG_RETRY_BIT   7
`define LDC_CFG_SINK_BIT    4
`define LDC_CFG_INRUSH_BIT  3
`define LDC_CFG_PWM_LSB     0
`define LDC_CTRL_RESET      8'h00

// ****************************************
// timing, in ns, and cycle counts
// ****************************************
`define LDC_PWM100_PERIOD_NS 10000000
`define LDC_PWM1K_PERIOD_NS  1000000
`define LDC_PWM_STEPS        128
`define LDC_PWM100_STEP_CYC  ((`LDC_PWM100_PERIOD_NS / `LDC_CLK_PERIOD_NS) / `LDC_PWM_STEPS)
`define LDC_PWM1K_STEP_CYC   ((`LDC_PWM1K_PERIOD_NS / `LDC_CLK_PERIOD_NS) / `LDC_PWM_STEPS)
`define LDC_OC_QUAL_NS       1000
`define LDC_OC_QUAL_CYC      ((`LDC_OC_QUAL_NS + `LDC_CLK_PERIOD_NS - 1) / `LDC_CLK_PERIOD_NS)
`define LDC_INRUSH_NS        20000
`define LDC_INRUSH_CYC       ((`LDC_INRUSH_NS + `LDC_CLK_PERIOD_NS - 1) / `LDC_CLK_PERIOD_NS)
`define LDC_RETRY_ON_NS      10000
`define LDC_RETRY_ON_CYC     ((`LDC_RETRY_ON_NS + `LDC_CLK_PERIOD_NS - 1) / `LDC_CLK_PERIOD_NS)
`define LDC_RETRY_OFF_NS     100000
`define LDC_RETRY_OFF_CYC    ((`LDC_RETRY_OFF_NS + `LDC_CLK_PERIOD_NS - 1) / `LDC_CLK_PERIOD_NS)

`endif

// ### hw/ldc_pkg.sv
// types for the lamp driver control block
package ldc_pkg;

   // pwm source select, configuration bits 1:0
   typedef enum logic [1:0] {
      LDC_PWM_NONE  = 2'h0,
      LDC_PWM_100HZ = 2'h1,
      LDC_PWM_1KHZ  = 2'h2,
      LDC_PWM_EXTF  = 2'h3
   } ldc_pwm_mode_t;

   // over-current protection states
   typedef enum logic [1:0] {
      LDC_ST_RUN,
      LDC_ST_RETRY_OFF,
      LDC_ST_RETRY_ON,
      LDC_ST_LATCHED
   } ldc_oc_state_t;

   typedef logic [23:0] ldc_cnt_t;

endpackage

// ### hw/ldc_pwm_gen.sv
// internal pwm generator with 7-bit duty
`timescale 1ns/1ps
`include "ldc_defines.svh"
module ldc_pwm_gen
   import ldc_pkg::*;
#(
   parameter int STEP100_CYC = `LDC_PWM100_STEP_CYC,
   parameter int STEP1K_CYC  = `LDC_PWM1K_STEP_CYC
) (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   ldc_pwm_if.gen    pwm
);
   import ldc_pkg::*;

   logic [23:0] step_cnt_reg, step_cnt_next;
   logic [6:0]  phase_reg,    phase_next;
   logic        pwm_reg,      pwm_next;
   logic [23:0] step_len;

   // ****************************************
   // step timing and phase
   // ****************************************
   // ext-frequency mode reuses the 1 khz step; ext edges restart the period
   always_comb begin
      step_len      = (pwm.mode == LDC_PWM_100HZ) ? 24'(STEP100_CYC) : 24'(STEP1K_CYC);
      step_cnt_next = step_cnt_reg;
      phase_next    = phase_reg;
      if (pwm.mode == LDC_PWM_NONE) begin
         step_cnt_next = 24'h000000;
         phase_next    = 7'h00;
      end else if (pwm.mode == LDC_PWM_EXTF && pwm.ext_edge) begin
         step_cnt_next = 24'h000000;
         phase_next    = 7'h00;
      end else if (step_cnt_reg >= step_len - 24'h000001) begin
         step_cnt_next = 24'h000000;
         // ext-frequency mode holds at the end until the next edge
         if (!(pwm.mode == LDC_PWM_EXTF && phase_reg == 7'h7f)) begin
            phase_next = phase_reg + 7'h01;
         end
      end else begin
         step_cnt_next = step_cnt_reg + 24'h000001;
      end
      // [RULE6] duty from control bits
      // mode none passes the demand straight through
      pwm_next = (pwm.mode == LDC_PWM_NONE) ? 1'b1 : (phase_next < pwm.duty);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         step_cnt_reg <= 24'h000000;
         phase_reg    <= 7'h00;
         pwm_reg      <= 1'b0;
      end else begin
         step_cnt_reg <= step_cnt_next;
         phase_reg    <= phase_next;
         pwm_reg      <= pwm_next;
      end
   end

   assign pwm.pwm_on = pwm_reg;

   // ****************************************
   // checks
   // ****************************************
   // [RULE6] zero duty stays low
   a_pwm_zero_duty: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (pwm.mode != LDC_PWM_NONE && pwm.duty == 7'h00) |=> !pwm_reg) // [RULE6]
      else $error("pwm high with zero duty");
   // [RULE8] mode none passes through
   a_pwm_none_pass: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (pwm.mode == LDC_PWM_NONE) |=> pwm_reg) // [RULE8]
      else $error("pwm gate closed in mode none");
   c_pwm_toggles: cover property (@(posedge core_clk_in) disable iff (rst_in)
      (pwm.mode == LDC_PWM_1KHZ) ##1 $fell(pwm_reg));
endmodule

// ### hw/ldc_pwm_if.sv
// link between lamp control core and its pwm generator
`timescale 1ns/1ps
interface ldc_pwm_if;
   import ldc_pkg::*;
   ldc_pwm_mode_t mode;
   logic [6:0]    duty;
   logic          ext_edge;
   logic          pwm_on;

   modport gen (input mode, input duty, input ext_edge, output pwm_on);
   modport ctl (output mode, output duty, output ext_edge, input pwm_on);
endinterface

// ### hw/ldc_top.sv
// lamp driver control: on/off, pwm, over-current retry, open-load sink
`timescale 1ns/1ps
`include "ldc_defines.svh"

// Behaviour
// [RULE1] lamp bit in on/off word switches output
// [RULE2] retry: short on, long off under over-current
// [RULE3] config bit 4 gates open-load sink
// [RULE4] sink detects open filament as open-load
// [RULE5] config bit 3 adds inrush qualification delay
// [RULE6] internal pwm duty from control low bits
// [RULE7] host supplies external duty on input pin
// [RULE8] config bits 1:0 select pwm source
// [RULE9] config resets to sink and inrush enabled
// [RULE10] retry and inrush times are parameters
// [RULE11] over-current and open-load latched, readable
module ldc_top
   import ldc_pkg::*;
#(
   parameter int OC_QUAL_CYC   = `LDC_OC_QUAL_CYC,
   parameter int INRUSH_CYC    = `LDC_INRUSH_CYC,
   parameter int RETRY_ON_CYC  = `LDC_RETRY_ON_CYC,
   parameter int RETRY_OFF_CYC = `LDC_RETRY_OFF_CYC,
   parameter int STEP100_CYC   = `LDC_PWM100_STEP_CYC,
   parameter int STEP1K_CYC    = `LDC_PWM1K_STEP_CYC
) (
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic       cfg_wr_in,
   input  wire logic [7:0] cfg_data_in,
   input  wire logic       ctrl_wr_in,
   input  wire logic [7:0] ctrl_data_in,
   input  wire logic       lamp_on_in,
   input  wire logic       ext_pwm_in,
   input  wire logic       oc_detect_in,
   input  wire logic       open_load_detect_in,
   input  wire logic       fault_clr_in,
   output logic            lamp_output_out,
   output logic            ol_sink_en_out,
   output logic [7:0]      cfg_out,
   output logic [7:0]      ctrl_out,
   output logic            oc_fault_out,
   output logic            open_load_fault_out
);
   import ldc_pkg::*;

   ldc_pwm_if pwm_bus ();

   logic [7:0]    cfg_reg,      cfg_next;
   logic [7:0]    ctrl_reg,     ctrl_next;
   logic          ext_prev_reg, ext_prev_next;
   ldc_oc_state_t st_reg,       st_next;
   ldc_cnt_t      qual_cnt_reg, qual_cnt_next;
   ldc_cnt_t      tmr_reg,      tmr_next;
   logic          out_reg,      out_next;
   logic          sink_reg,     sink_next;
   logic          oc_flt_reg,   oc_flt_next;
   logic          ol_flt_reg,   ol_flt_next;
   logic          demand;
   logic          oc_set;
   ldc_cnt_t      qual_limit;

   // saturation-safe end-of-count test, used by both retry timers; qualification compares inline
   function automatic logic cnt_done(input ldc_cnt_t cnt, input int lim);
      cnt_done = (cnt >= ldc_cnt_t'(lim) - 24'h000001);
   endfunction

   // ****************************************
   // register writes
   // ****************************************
   always_comb begin
      cfg_next      = cfg_reg;
      ctrl_next     = ctrl_reg;
      ext_prev_next = ext_pwm_in;
      // [RULE9] unused bits stay zero
      if (cfg_wr_in) begin
         cfg_next = cfg_data_in & `LDC_CFG_USED_MASK;
      end
      if (ctrl_wr_in) begin
         ctrl_next = ctrl_data_in;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_reg      <= `LDC_CFG_RESET;
         ctrl_reg     <= `LDC_CTRL_RESET;
         ext_prev_reg <= 1'b0;
      end else begin
         cfg_reg      <= cfg_next;
         ctrl_reg     <= ctrl_next;
         ext_prev_reg <= ext_prev_next;
      end
   end

   // ****************************************
   // pwm generator
   // ****************************************
   // [RULE8] source select from config bits 1:0
   assign pwm_bus.mode     = ldc_pwm_mode_t'(cfg_reg[`LDC_CFG_PWM_LSB +: 2]);
   assign pwm_bus.duty     = ctrl_reg[6:0];
   assign pwm_bus.ext_edge = ext_pwm_in & ~ext_prev_reg;

   ldc_pwm_gen #(
      .STEP100_CYC (STEP100_CYC),
      .STEP1K_CYC  (STEP1K_CYC)
   ) u_pwm (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .pwm         (pwm_bus.gen)
   );

   // ****************************************
   // output demand and over-current protection
   // ****************************************
   always_comb begin
      // [RULE1] lamp bit switches the output
      // [RULE7] in mode none the host may drive duty on the pin
      demand = (lamp_on_in | (pwm_bus.mode == LDC_PWM_NONE && ext_pwm_in)) & pwm_bus.pwm_on;
      // [RULE5] inrush bit lengthens qualification
      qual_limit = cfg_reg[`LDC_CFG_INRUSH_BIT] ? ldc_cnt_t'(OC_QUAL_CYC + INRUSH_CYC)
                                                : ldc_cnt_t'(OC_QUAL_CYC);
      st_next       = st_reg;
      qual_cnt_next = 24'h000000;
      tmr_next      = tmr_reg;
      oc_set        = 1'b0;
      out_next      = 1'b0;
      case (st_reg)
         LDC_ST_RUN: begin
            out_next = demand;
            // only time over-current while the switch is closed
            if (out_reg && oc_detect_in) begin
               if (qual_cnt_reg >= qual_limit - 24'h000001) begin
                  oc_set   = 1'b1;
                  out_next = 1'b0;
                  tmr_next = 24'h000000;
                  st_next  = cfg_reg[`LDC_CFG_RETRY_BIT] ? LDC_ST_RETRY_OFF : LDC_ST_LATCHED;
               end else begin
                  qual_cnt_next = qual_cnt_reg + 24'h000001;
               end
            end
         end
         // [RULE2] long off period
         // [RULE10] parameterised retry times
         LDC_ST_RETRY_OFF: begin
            tmr_next = tmr_reg + 24'h000001;
            if (cnt_done(tmr_reg, RETRY_OFF_CYC)) begin
               tmr_next = 24'h000000;
               st_next  = LDC_ST_RETRY_ON;
            end
         end
         // [RULE2] short on probe, no inrush grace
         LDC_ST_RETRY_ON: begin
            out_next = demand;
            tmr_next = tmr_reg + 24'h000001;
            if (out_reg && oc_detect_in) begin
               oc_set   = 1'b1;
               out_next = 1'b0;
               tmr_next = 24'h000000;
               st_next  = LDC_ST_RETRY_OFF;
            end else if (cnt_done(tmr_reg, RETRY_ON_CYC)) begin
               tmr_next = 24'h000000;
               st_next  = LDC_ST_RUN;
            end
         end
         // stays off until fault is cleared or lamp is commanded off
         LDC_ST_LATCHED: begin
            if (fault_clr_in || !lamp_on_in) begin
               st_next = LDC_ST_RUN;
            end
         end
         default: begin
            st_next = LDC_ST_RUN;
         end
      endcase
      // [RULE3] sink follows config bit 4
      sink_next = cfg_reg[`LDC_CFG_SINK_BIT];
      // [RULE11] sticky faults, set wins over clear
      oc_flt_next = oc_set | (oc_flt_reg & ~fault_clr_in);
      // [RULE4] open filament seen only with sink on and switch open
      ol_flt_next = (sink_reg & ~out_reg & open_load_detect_in)
                    | (ol_flt_reg & ~fault_clr_in);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg       <= LDC_ST_RUN;
         qual_cnt_reg <= 24'h000000;
         tmr_reg      <= 24'h000000;
         out_reg      <= 1'b0;
         sink_reg     <= 1'b1;
         oc_flt_reg   <= 1'b0;
         ol_flt_reg   <= 1'b0;
      end else begin
         st_reg       <= st_next;
         qual_cnt_reg <= qual_cnt_next;
         tmr_reg      <= tmr_next;
         out_reg      <= out_next;
         sink_reg     <= sink_next;
         oc_flt_reg   <= oc_flt_next;
         ol_flt_reg   <= ol_flt_next;
      end
   end

   assign lamp_output_out     = out_reg;
   assign ol_sink_en_out      = sink_reg;
   assign cfg_out             = cfg_reg;
   assign ctrl_out            = ctrl_reg;
   assign oc_fault_out        = oc_flt_reg;
   assign open_load_fault_out = ol_flt_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   // [RULE1] command off opens switch
   a_cmd_off_output: assert property ((!lamp_on_in && !ext_pwm_in) |=> !lamp_output_out) // [RULE1]
      else $error("output on without command");
   // [RULE1] command on closes switch
   a_cmd_on_output: assert property ((lamp_on_in && st_reg == LDC_ST_RUN && !oc_detect_in
      && pwm_bus.mode == LDC_PWM_NONE && pwm_bus.pwm_on) |=> lamp_output_out) // [RULE1]
      else $error("output off despite command");
   // [RULE2] retry off period holds output low
   a_retry_off_low: assert property ((st_reg == LDC_ST_RETRY_OFF) |=> !lamp_output_out) // [RULE2]
      else $error("output on during retry off");
   // [RULE3] sink tracks bit 4
   a_sink_follows_cfg: assert property (cfg_wr_in |=> ##1 ol_sink_en_out == $past(cfg_data_in[4], 2)) // [RULE3]
      else $error("sink does not follow config");
   // [RULE4] open-load only with sink on
   a_ol_needs_sink: assert property ($rose(open_load_fault_out) |-> $past(ol_sink_en_out)) // [RULE4]
      else $error("open-load flagged with sink off");
   // [RULE5] fault rises only at qualification limit
   a_inrush_qual: assert property (($rose(oc_fault_out) && $past(st_reg) == LDC_ST_RUN)
      |-> $past(qual_cnt_reg) == $past(qual_limit) - 24'h000001) // [RULE5]
      else $error("over-current flagged before qualification");
   // [RULE9] unused config bits read zero
   a_cfg_unused_zero: assert property ((cfg_out & ~`LDC_CFG_USED_MASK) == 8'h00) // [RULE9]
      else $error("unused config bits set");
   // [RULE11] fault sticky until cleared
   a_oc_sticky: assert property ((oc_fault_out && !fault_clr_in) |=> oc_fault_out) // [RULE11]
      else $error("over-current fault dropped");
   // [RULE11] latched state keeps output off
   a_latched_off: assert property ((st_reg == LDC_ST_LATCHED) |=> !lamp_output_out) // [RULE11]
      else $error("output on while latched");

   c_retry_cycle: cover property (st_reg == LDC_ST_RETRY_OFF ##1 st_reg == LDC_ST_RETRY_ON);
   c_oc_latched: cover property ($rose(st_reg == LDC_ST_LATCHED));
   c_open_load: cover property ($rose(open_load_fault_out));
endmodule

// ### sim/lamp_driver_control_tb.sv
// self-checking bench for the lamp driver control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module lamp_driver_control_tb;
   import ldc_pkg::*;
   localparam int QUAL = 4;
   localparam int ROFF = 20;
   localparam int S100 = 2;
   localparam int S1K  = 1;
   logic       core_clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       cfg_wr_in = 1'b0, ctrl_wr_in = 1'b0, lamp_on_in = 1'b0;
   logic       ext_pwm_in = 1'b0, fault_clr_in = 1'b0, short_cmd = 1'b0, open_cmd = 1'b0;
   logic [7:0] cfg_data_in = 8'h00, ctrl_data_in = 8'h00, inrush_len = 8'h00;
   logic       oc_detect_in, open_load_detect_in, lamp_output_out, ol_sink_en_out;
   logic       oc_fault_out, open_load_fault_out;
   logic [7:0] cfg_out, ctrl_out, r;
   int         checked = 0, bad_count = 0, cycles = 0, hi, n1, off_n, on_n;
   integer     seed = 32'hc2ac281d;

   ldc_top #(.OC_QUAL_CYC(QUAL), .INRUSH_CYC(8), .RETRY_ON_CYC(5), .RETRY_OFF_CYC(ROFF),
             .STEP100_CYC(S100), .STEP1K_CYC(S1K)) u_ldc_top (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
      .cfg_data_in(cfg_data_in), .ctrl_wr_in(ctrl_wr_in), .ctrl_data_in(ctrl_data_in),
      .lamp_on_in(lamp_on_in), .ext_pwm_in(ext_pwm_in), .oc_detect_in(oc_detect_in),
      .open_load_detect_in(open_load_detect_in), .fault_clr_in(fault_clr_in),
      .lamp_output_out(lamp_output_out), .ol_sink_en_out(ol_sink_en_out),
      .cfg_out(cfg_out), .ctrl_out(ctrl_out), .oc_fault_out(oc_fault_out),
      .open_load_fault_out(open_load_fault_out));

   ldc_lamp_model u_ldc_lamp_model (
      .core_clk_in(core_clk_in), .gate_in(lamp_output_out), .sink_en_in(ol_sink_en_out),
      .short_in(short_cmd), .open_in(open_cmd), .inrush_in(inrush_len),
      .oc_out(oc_detect_in), .open_out(open_load_detect_in));

   // ****************************************
   // clock, timeout and helpers
   // ****************************************
   always #5 core_clk_in = ~core_clk_in;

   // run is about 3350 cycles; the ceiling leaves ample room
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 10000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // step past the edge so its register updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask

   // one-cycle write strobe; sel high for config, low for lamp control
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge core_clk_in);
      cfg_wr_in <= sel;
      ctrl_wr_in <= ~sel;
      cfg_data_in <= d;
      ctrl_data_in <= d;
      @(posedge core_clk_in);
      cfg_wr_in <= 1'b0;
      ctrl_wr_in <= 1'b0;
      tick(2);
   endtask

   // cycles the output holds a level, bounded so a stuck output cannot hang
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (lamp_output_out === lvl && n < 200) begin
         tick(1);
         n++;
      end
   endtask

   function automatic int exp_hi(input logic [6:0] d, input int step);
      return int'(d) * step;
   endfunction

   function automatic logic [7:0] exp_cfg(input logic [7:0] d);
      return d & 8'h9b;
   endfunction

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge core_clk_in);
      #1;
      `CHK(cfg_out, 8'h18)
      `CHK({ctrl_out, ol_sink_en_out}, 9'h001)
      `CHK({lamp_output_out, oc_fault_out, open_load_fault_out}, 3'h0)
      @(posedge core_clk_in);
      rst_in <= 1'b0;
      // random register traffic, unused config bits must read zero
      for (int i = 0; i < 8; i++) begin
         r = 8'($random(seed));
         wr(1'b1, r);
         `CHK(cfg_out, exp_cfg(r))
         `CHK(ol_sink_en_out, r[4])
         wr(1'b0, r ^ 8'h5a);
         `CHK(ctrl_out, r ^ 8'h5a)
      end
      // mode 00: lamp bit or external pin drives the switch directly
      wr(1'b1, 8'h08);
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk_in);
         r = 8'($random(seed));
         lamp_on_in <= r[0];
         ext_pwm_in <= r[1] & r[2];
         tick(1);
         `CHK(lamp_output_out, r[0] | (r[1] & r[2]))
      end
      // internal pwm: on-cycles over one full period equal duty times step
      @(posedge core_clk_in);
      lamp_on_in <= 1'b1;
      ext_pwm_in <= 1'b0;
      for (int m = 1; m < 3; m++) begin
         for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 8'h80 : (k == 1) ? 8'hff : 8'($random(seed));
            wr(1'b1, 8'(m));
            wr(1'b0, r);
            tick(260);
            hi = 0;
            repeat (128 * ((m == 1) ? S100 : S1K)) begin
               tick(1);
               hi += int'(lamp_output_out);
            end
            `CHK(hi, exp_hi(r[6:0], (m == 1) ? S100 : S1K))
         end
      end
      // mode 11 with zero duty: pin edges only set frequency, never turn on
      wr(1'b1, 8'h03);
      wr(1'b0, 8'h00);
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk_in);
         ext_pwm_in <= i[1];
         tick(1);
         `CHK(lamp_output_out, 1'b0)
      end
      // mode 11 with duty 16: phase holds at its end, output low, until a pin edge restarts it
      wr(1'b0, 8'h10);
      @(posedge core_clk_in);
      ext_pwm_in <= 1'b0;
      tick(200);
      `CHK(lamp_output_out, 1'b0)
      @(posedge core_clk_in);
      ext_pwm_in <= 1'b1;
      tick(2);
      run_len(1'b1, hi);
      `CHK(hi, exp_hi(7'h10, S1K))
      // cold filament inrush of 10 cycles: tolerated only with the extra delay
      @(posedge core_clk_in);
      lamp_on_in <= 1'b0;
      ext_pwm_in <= 1'b0;
      inrush_len <= 8'h0a;
      wr(1'b1, 8'h08);
      @(posedge core_clk_in);
      lamp_on_in <= 1'b1;
      tick(30);
      `CHK({lamp_output_out, oc_fault_out}, 2'b10)
      @(posedge core_clk_in);
      lamp_on_in <= 1'b0;
      wr(1'b1, 8'h00);
      @(posedge core_clk_in);
      lamp_on_in <= 1'b1;
      tick(QUAL + 4);
      `CHK({lamp_output_out, oc_fault_out}, 2'b01)
      tick(30);
      `CHK({lamp_output_out, oc_fault_out}, 2'b01)
      // retry under a hard short: brief on, long off
      @(posedge core_clk_in);
      lamp_on_in <= 1'b0;
      inrush_len <= 8'h00;
      short_cmd <= 1'b1;
      wr(1'b1, 8'h80);
      @(posedge core_clk_in);
      lamp_on_in <= 1'b1;
      tick(1);
      run_len(1'b1, n1);
      run_len(1'b0, off_n);
      run_len(1'b1, on_n);
      `CHK(n1 >= QUAL && n1 <= QUAL + 2, 1'b1)
      `CHK(off_n >= ROFF - 1 && off_n <= ROFF + 3, 1'b1)
      `CHK(on_n >= 1 && on_n < 4 && oc_fault_out === 1'b1, 1'b1)
      @(posedge core_clk_in);
      short_cmd <= 1'b0;
      tick(60);
      `CHK(lamp_output_out, 1'b1)
      // open filament: seen only while the sink is on, then sticky until cleared
      @(posedge core_clk_in);
      lamp_on_in <= 1'b0;
      open_cmd <= 1'b1;
      fault_clr_in <= 1'b1;
      @(posedge core_clk_in);
      fault_clr_in <= 1'b0;
      wr(1'b1, 8'h00);
      tick(5);
      `CHK({oc_fault_out, open_load_fault_out}, 2'b00)
      wr(1'b1, 8'h10);
      tick(3);
      `CHK(open_load_fault_out, 1'b1)
      @(posedge core_clk_in);
      open_cmd <= 1'b0;
      tick(4);
      `CHK(open_load_fault_out, 1'b1)
      @(posedge core_clk_in);
      fault_clr_in <= 1'b1;
      @(posedge core_clk_in);
      fault_clr_in <= 1'b0;
      tick(2);
      `CHK(open_load_fault_out, 1'b0)
      // second reset mid-run brings registers back to defaults
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      tick(2);
      `CHK({cfg_out, ctrl_out, ol_sink_en_out}, 17'h03001)
      `CHK({lamp_output_out, oc_fault_out, open_load_fault_out}, 3'h0)
      @(posedge core_clk_in);
      rst_in <= 1'b0;
      wr(1'b1, 8'h81);
      `CHK(cfg_out, exp_cfg(8'h81))
      end_sim();
   end
endmodule

// ### sim/ldc_lamp_model.sv
// behavioural lamp or led load hanging on the low-side output
`timescale 1ns/1ps
module ldc_lamp_model (
   input  wire logic       core_clk_in,
   input  wire logic       gate_in,
   input  wire logic       sink_en_in,
   input  wire logic       short_in,
   input  wire logic       open_in,
   input  wire logic [7:0] inrush_in,
   output logic            oc_out,
   output logic            open_out
);
   // ****************************************
   // load behaviour
   // ****************************************
   logic [7:0] on_cnt_reg = 8'h00;

   // cycles since the switch closed; saturates so a long on-time never wraps
   always @(posedge core_clk_in) begin
      if (!gate_in) begin
         on_cnt_reg <= 8'h00;
      end else if (on_cnt_reg != 8'hff) begin
         on_cnt_reg <= on_cnt_reg + 8'h01;
      end
   end

   // cold filament draws high current at first; a shorted load always does
   assign oc_out = gate_in & (short_in | (on_cnt_reg < inrush_in));
   // no filament: only the sink pulls an off output low, so open shows then only
   assign open_out = open_in & sink_en_in & ~gate_in;
endmodule
